// [core/pwmc_pkg.sv]
// constants and types for the pwm-mode counter channel
package pwmc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_CMD       = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_COUNT     = 8'h0c;
  localparam logic [7:0] OFS_COMPARE   = 8'h10;
  localparam logic [7:0] OFS_CMP_SHAD  = 8'h14;
  localparam logic [7:0] OFS_PERIOD    = 8'h18;
  localparam logic [7:0] OFS_PER_SHAD  = 8'h1c;
  localparam logic [7:0] OFS_TRIG      = 8'h20;
  localparam int         NUM_REGS      = 9;
  // control fields
  localparam int CTRL_MODE_POS   = 0;
  localparam int CTRL_ONESHOT    = 2;
  localparam int CTRL_CMP_SWAP   = 3;
  localparam int CTRL_PER_SWAP   = 4;
  localparam int CTRL_HALT_KILL  = 5;
  localparam int CTRL_SYNC_KILL  = 6;
  localparam int CTRL_POL        = 7;
  localparam int CTRL_POL_N      = 8;
  localparam int CTRL_PSC_POS    = 9;
  localparam int CTRL_OV_POS     = 12;
  localparam int CTRL_UN_POS     = 14;
  localparam int CTRL_CC_POS     = 16;
  localparam logic [31:0] CTRL_MASK  = 32'h0003_ffff;
  localparam logic [31:0] CTRL_RESET = 32'h0000_d000;
  // command bits, self clearing
  localparam int CMD_RELOAD = 0;
  localparam int CMD_START  = 1;
  localparam int CMD_KILL   = 2;
  localparam int CMD_SWAP   = 3;
  // status bits
  localparam int STAT_RUN   = 0;
  localparam int STAT_DIR   = 1;
  localparam int STAT_SUPP  = 2;
  localparam int STAT_SWAP  = 3;
  // trigger detect modes, two bits per input: reload,start,kill,count,swap
  localparam int          TRIG_W     = 2;
  localparam logic [31:0] TRIG_MASK  = 32'h0000_03ff;
  localparam logic [31:0] TRIG_RESET = 32'h0000_00c0;
  localparam int EV_RELOAD = 0;
  localparam int EV_START  = 1;
  localparam int EV_KILL   = 2;
  localparam int EV_COUNT  = 3;
  localparam int EV_SWAP   = 4;
  localparam int NUM_EV    = 5;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    PWMC_UP     = 2'b00,
    PWMC_DOWN   = 2'b01,
    PWMC_CENTRE = 2'b10,
    PWMC_ASYM   = 2'b11
  } pwmc_updown_t;

  typedef enum logic [1:0] {
    PWMC_SET    = 2'b00,
    PWMC_CLEAR  = 2'b01,
    PWMC_INVERT = 2'b10,
    PWMC_KEEP   = 2'b11
  } pwmc_action_t;

  typedef enum logic [1:0] {
    PWMC_RISE  = 2'b00,
    PWMC_FALL  = 2'b01,
    PWMC_BOTH  = 2'b10,
    PWMC_LEVEL = 2'b11
  } pwmc_edge_t;
endpackage

// [core/pwmc_top.sv]
// pwm-mode counter channel with axi4-lite register slave
// Operation
// - reload loads 0, period or 1, starts
// - reload and start only act when stopped
// - start keeps count, sets direction by mode
// - count event steps one in direction
// - terminal after swap exchanges compare/period shadows
// - swap pends while running, dropped when stopped
// - prescaler divides clock to qualify counting
// - one-shot stops on overflow in up mode, else on underflow
// - up mode counts 0 to period
// - down mode counts period to 0
// - up/down counts 1 to period to 0
// - equality of count and compare hits
// - true and complementary outputs from events
// - halt-on-kill stops counter until reload/start
// - async kill suppresses while kill active
// - sync kill suppresses until clean terminal
// - terminal event chosen by counting mode
// - up/down hit on leaving, else entering
// - events set, clear or invert line
// - overflow/underflow action before compare action
`timescale 1ns/1ps
`default_nettype none
module pwmc_top #(
  parameter int WIDTH = 16
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        wvalid,
  output var  logic        wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output var  logic        bvalid,
  input  wire logic        bready,
  output var  logic [1:0]  bresp,
  input  wire logic        arvalid,
  output var  logic        arready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  output var  logic        rvalid,
  input  wire logic        rready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  input  wire logic        reload_in,
  input  wire logic        start_in,
  input  wire logic        kill_in,
  input  wire logic        count_in,
  input  wire logic        swap_in,
  output var  logic        pwm,
  output var  logic        pwm_n,
  output var  logic        overflow,
  output var  logic        underflow,
  output var  logic        compare_hit,
  output var  logic        terminal_event
);
  if (WIDTH < 2 || WIDTH > 32) begin : g_chk
    $error("pwmc_top: WIDTH must be 2..32");
  end

  localparam logic [WIDTH-1:0] ONE = WIDTH'(1);

  function automatic logic [3:0] reg_index(input logic [7:0] a);
    return a[5:2];
  endfunction
  function automatic logic reg_ok(input logic [7:0] a);
    return (a[7:6] == 2'b00) && (a[5:2] < 4'(pwmc_pkg::NUM_REGS));
  endfunction
  function automatic logic edge_det(input logic [1:0] m, input logic cur,
                                    input logic prev);
    unique case (pwmc_pkg::pwmc_edge_t'(m))
      pwmc_pkg::PWMC_RISE:  return cur & ~prev;
      pwmc_pkg::PWMC_FALL:  return ~cur & prev;
      pwmc_pkg::PWMC_BOTH:  return cur ^ prev;
      pwmc_pkg::PWMC_LEVEL: return cur;
    endcase
  endfunction
  function automatic logic act(input logic [1:0] a, input logic l);
    unique case (pwmc_pkg::pwmc_action_t'(a))
      pwmc_pkg::PWMC_SET:    return 1'b1;
      pwmc_pkg::PWMC_CLEAR:  return 1'b0;
      pwmc_pkg::PWMC_INVERT: return ~l;
      pwmc_pkg::PWMC_KEEP:   return l;
    endcase
  endfunction

  // ---------------- axi4-lite slave
  logic        aw_held, w_held, wr_fire;
  logic [7:0]  aw_addr_q;
  logic [31:0] wdata_q, wr_old, wr_data;
  logic [3:0]  wstrb_q;
  logic [31:0] view [pwmc_pkg::NUM_REGS];
  logic [3:0]  wr_idx;

  assign wr_fire = aw_held & w_held & ~bvalid;
  assign wr_idx  = reg_index(aw_addr_q);

  always_comb begin
    wr_old = reg_ok(aw_addr_q) ? view[wr_idx] : 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      wr_data[8*b +: 8] = wstrb_q[b] ? wdata_q[8*b +: 8] : wr_old[8*b +: 8];
    end
  end

  function automatic logic hits(input logic [7:0] ofs);
    return wr_fire && reg_ok(aw_addr_q) && (wr_idx == reg_index(ofs));
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      awready   <= 1'b1;
      wready    <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= pwmc_pkg::RESP_OKAY;
      aw_addr_q <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_held   <= 1'b1;
        awready   <= 1'b0;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held  <= 1'b1;
        wready  <= 1'b0;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= reg_ok(aw_addr_q) ? pwmc_pkg::RESP_OKAY
                                     : pwmc_pkg::RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= pwmc_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= reg_ok(araddr) ? view[reg_index(araddr)] : 32'h0000_0000;
      rresp   <= reg_ok(araddr) ? pwmc_pkg::RESP_OKAY
                                : pwmc_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ---------------- configuration and commands
  logic [31:0] ctrl, trig;
  logic [3:0]  cmd;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= pwmc_pkg::CTRL_RESET;
      trig <= pwmc_pkg::TRIG_RESET;
      cmd  <= 4'h0;
    end else begin
      if (hits(pwmc_pkg::OFS_CTRL)) ctrl <= wr_data & pwmc_pkg::CTRL_MASK;
      if (hits(pwmc_pkg::OFS_TRIG)) trig <= wr_data & pwmc_pkg::TRIG_MASK;
      // one-cycle pulses; a byte lane not strobed issues nothing
      cmd <= hits(pwmc_pkg::OFS_CMD) && wstrb_q[0] ? wdata_q[3:0] : 4'h0;
    end
  end

  pwmc_pkg::pwmc_updown_t mode;
  logic       one_shot, halt_kill, sync_kill, updn;
  logic [2:0] psc;
  assign mode      = pwmc_pkg::pwmc_updown_t'(ctrl[pwmc_pkg::CTRL_MODE_POS +: 2]);
  assign one_shot  = ctrl[pwmc_pkg::CTRL_ONESHOT];
  assign halt_kill = ctrl[pwmc_pkg::CTRL_HALT_KILL];
  assign sync_kill = ctrl[pwmc_pkg::CTRL_SYNC_KILL];
  assign psc       = ctrl[pwmc_pkg::CTRL_PSC_POS +: 3];
  assign updn      = (mode == pwmc_pkg::PWMC_CENTRE) ||
                     (mode == pwmc_pkg::PWMC_ASYM);

  // ---------------- trigger inputs: three-stage sync, then detection
  logic [pwmc_pkg::NUM_EV-1:0] pins, s1, s2, s3, filt, prev, ev;
  assign pins = {swap_in, count_in, kill_in, start_in, reload_in};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= '0; s2 <= '0; s3 <= '0; filt <= '0; prev <= '0;
    end else begin
      s1   <= pins;
      s2   <= s1;
      s3   <= s2;
      filt <= (s2 & s3) | (filt & (s2 ^ s3));
      prev <= filt;
    end
  end
  always_comb begin
    for (int i = 0; i < pwmc_pkg::NUM_EV; i++) begin
      ev[i] = edge_det(trig[pwmc_pkg::TRIG_W*i +: 2], filt[i], prev[i]);
    end
    ev[pwmc_pkg::EV_RELOAD] |= cmd[pwmc_pkg::CMD_RELOAD];
    ev[pwmc_pkg::EV_START]  |= cmd[pwmc_pkg::CMD_START];
    ev[pwmc_pkg::EV_KILL]   |= cmd[pwmc_pkg::CMD_KILL];
    ev[pwmc_pkg::EV_SWAP]   |= cmd[pwmc_pkg::CMD_SWAP];
  end

  // ---------------- prescaler, divide by 2**psc
  logic [6:0] pre;
  logic       tick;
  always_ff @(posedge aclk) begin
    if (!aresetn) pre <= 7'h00;
    else          pre <= pre + 7'h01;
  end
  assign tick = (pre & 7'((8'h01 << psc) - 8'h01)) == 7'h00;

  // ---------------- counter core
  logic             running, dir_up, swap_pending, sup_sync, line;
  logic [WIDTH-1:0] count, compare_value, compare_shadow;
  logic [WIDTH-1:0] period, period_shadow, next_count;
  logic             next_dir, ovf, unf, hit, tc, cnt_step, load, start;
  logic             kill_stop, shot_stop, suppress, next_line;

  assign kill_stop = halt_kill & ev[pwmc_pkg::EV_KILL];
  assign load  = ~running & ev[pwmc_pkg::EV_RELOAD] & ~kill_stop;
  assign start = ~running & ev[pwmc_pkg::EV_START] & ~kill_stop;
  assign cnt_step = running & ev[pwmc_pkg::EV_COUNT] & tick;

  always_comb begin
    next_count = count;
    next_dir   = dir_up;
    ovf        = 1'b0;
    unf        = 1'b0;
    if (cnt_step) begin
      unique case (mode)
        pwmc_pkg::PWMC_UP: begin
          if (count == period) begin
            ovf        = 1'b1;
            next_count = '0;
          end else next_count = count + ONE;
        end
        pwmc_pkg::PWMC_DOWN: begin
          if (count == '0) begin
            unf        = 1'b1;
            next_count = period;
          end else next_count = count - ONE;
        end
        pwmc_pkg::PWMC_CENTRE, pwmc_pkg::PWMC_ASYM: begin
          if (dir_up) begin
            if (count == period) begin
              ovf        = 1'b1;
              next_dir   = 1'b0;
              next_count = count - ONE;
            end else next_count = count + ONE;
          end else if (count == '0) begin
            unf        = 1'b1;
            next_dir   = 1'b1;
            next_count = ONE;
          end else next_count = count - ONE;
        end
      endcase
    end
    // up/down: leaving the equal state; a reload counts as leaving 0
    hit = updn ? ((cnt_step && count == compare_value) ||
                  (load && compare_value == '0))
               : (cnt_step && next_count == compare_value);
    unique case (mode)
      pwmc_pkg::PWMC_UP:     tc = ovf;
      pwmc_pkg::PWMC_DOWN:   tc = unf;
      pwmc_pkg::PWMC_CENTRE: tc = unf;
      pwmc_pkg::PWMC_ASYM:   tc = ovf | unf;
    endcase
  end
  assign shot_stop = one_shot & (mode == pwmc_pkg::PWMC_UP ? ovf : unf);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      running <= 1'b0;
      dir_up  <= 1'b1;
    end else begin
      if (kill_stop || shot_stop) running <= 1'b0;
      else if (load || start)     running <= 1'b1;
      if (load || start) dir_up <= (mode != pwmc_pkg::PWMC_DOWN);
      else if (cnt_step) dir_up <= next_dir;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count          <= '0;
      compare_value  <= '0;
      compare_shadow <= '0;
      period         <= '0;
      period_shadow  <= '0;
    end else begin
      if (hits(pwmc_pkg::OFS_COUNT))    count          <= wr_data[WIDTH-1:0];
      if (hits(pwmc_pkg::OFS_COMPARE))  compare_value  <= wr_data[WIDTH-1:0];
      if (hits(pwmc_pkg::OFS_CMP_SHAD)) compare_shadow <= wr_data[WIDTH-1:0];
      if (hits(pwmc_pkg::OFS_PERIOD))   period         <= wr_data[WIDTH-1:0];
      if (hits(pwmc_pkg::OFS_PER_SHAD)) period_shadow  <= wr_data[WIDTH-1:0];
      if (load) begin
        unique case (mode)
          pwmc_pkg::PWMC_UP:   count <= '0;
          pwmc_pkg::PWMC_DOWN: count <= period;
          pwmc_pkg::PWMC_CENTRE, pwmc_pkg::PWMC_ASYM: count <= ONE;
        endcase
      end else if (cnt_step) count <= next_count;
      // software must keep period equal to its shadow in asym mode
      if (tc && swap_pending) begin
        if (ctrl[pwmc_pkg::CTRL_CMP_SWAP]) begin
          compare_value  <= compare_shadow;
          compare_shadow <= compare_value;
        end
        if (ctrl[pwmc_pkg::CTRL_PER_SWAP]) begin
          period        <= period_shadow;
          period_shadow <= period;
        end
      end
    end
  end

  // a new swap in the consuming cycle stays pending
  always_ff @(posedge aclk) begin
    if (!aresetn) swap_pending <= 1'b0;
    else if (!running) swap_pending <= 1'b0;
    else swap_pending <= ev[pwmc_pkg::EV_SWAP] |
                         (swap_pending & ~tc);
  end

  // sync kill: set wins over the clearing terminal event
  always_ff @(posedge aclk) begin
    if (!aresetn) sup_sync <= 1'b0;
    else if (halt_kill || !sync_kill) sup_sync <= 1'b0;
    else if (ev[pwmc_pkg::EV_KILL]) sup_sync <= 1'b1;
    else if (tc) sup_sync <= 1'b0;
  end
  assign suppress = (~halt_kill & ~sync_kill & ev[pwmc_pkg::EV_KILL])
                  | sup_sync;

  always_comb begin
    next_line = line;
    if (ovf) next_line = act(ctrl[pwmc_pkg::CTRL_OV_POS +: 2], next_line);
    if (unf) next_line = act(ctrl[pwmc_pkg::CTRL_UN_POS +: 2], next_line);
    if (hit) next_line = act(ctrl[pwmc_pkg::CTRL_CC_POS +: 2], next_line);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line           <= 1'b0;
      pwm            <= 1'b0;
      pwm_n          <= 1'b0;
      overflow       <= 1'b0;
      underflow      <= 1'b0;
      compare_hit    <= 1'b0;
      terminal_event <= 1'b0;
    end else begin
      line           <= next_line;
      pwm   <= ~suppress & (next_line ^ ctrl[pwmc_pkg::CTRL_POL]);
      pwm_n <= ~suppress & (~next_line ^ ctrl[pwmc_pkg::CTRL_POL_N]);
      overflow       <= ovf;
      underflow      <= unf;
      compare_hit    <= hit;
      terminal_event <= tc;
    end
  end

  always_comb begin
    for (int i = 0; i < pwmc_pkg::NUM_REGS; i++) view[i] = 32'h0000_0000;
    view[reg_index(pwmc_pkg::OFS_CTRL)]     = ctrl;
    view[reg_index(pwmc_pkg::OFS_STATUS)]   = {28'h0000000, swap_pending,
                                               suppress, dir_up, running};
    view[reg_index(pwmc_pkg::OFS_COUNT)]    = 32'(count);
    view[reg_index(pwmc_pkg::OFS_COMPARE)]  = 32'(compare_value);
    view[reg_index(pwmc_pkg::OFS_CMP_SHAD)] = 32'(compare_shadow);
    view[reg_index(pwmc_pkg::OFS_PERIOD)]   = 32'(period);
    view[reg_index(pwmc_pkg::OFS_PER_SHAD)] = 32'(period_shadow);
    view[reg_index(pwmc_pkg::OFS_TRIG)]     = trig;
  end

  property p_reload_up;
    @(posedge aclk) disable iff (!aresetn)
      (load && mode == pwmc_pkg::PWMC_UP) |=> (count == '0 && running);
  endproperty
  a_reload_up: assert property (p_reload_up) else $error("reload up fail");

  property p_no_restart;
    @(posedge aclk) disable iff (!aresetn)
      (running && ev[pwmc_pkg::EV_RELOAD] && !cnt_step
       && !hits(pwmc_pkg::OFS_COUNT)) |=> count == $past(count);
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("reload ran");

  property p_step_up;
    @(posedge aclk) disable iff (!aresetn)
      (cnt_step && mode == pwmc_pkg::PWMC_UP && count != period && !load
       && !hits(pwmc_pkg::OFS_COUNT)) |=> count == $past(count) + ONE;
  endproperty
  a_step_up: assert property (p_step_up) else $error("no step");

  property p_swap_drop;
    @(posedge aclk) disable iff (!aresetn)
      !running |=> !swap_pending;
  endproperty
  a_swap_drop: assert property (p_swap_drop) else $error("swap kept");

  property p_one_shot;
    @(posedge aclk) disable iff (!aresetn)
      (one_shot && mode == pwmc_pkg::PWMC_DOWN && unf) |=> !running ##1 1'b1;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("one-shot ran");

  property p_halt;
    @(posedge aclk) disable iff (!aresetn)
      kill_stop |=> !running;
  endproperty
  a_halt: assert property (p_halt) else $error("kill no stop");

  property p_async_kill;
    @(posedge aclk) disable iff (!aresetn)
      (!halt_kill && !sync_kill && ev[pwmc_pkg::EV_KILL])
        |=> (!pwm && !pwm_n && terminal_event == $past(tc));
  endproperty
  a_async_kill: assert property (p_async_kill) else $error("not killed");

  property p_tc_mode;
    @(posedge aclk) disable iff (!aresetn)
      (tc && mode == pwmc_pkg::PWMC_CENTRE) |-> unf ##1 (terminal_event && underflow);
  endproperty
  a_tc_mode: assert property (p_tc_mode) else $error("tc wrong");
endmodule // pwmc_top
`default_nettype wire

// [test/pwmc_trig_src.sv]
// trigger source model driving the channel's five trigger pins
`timescale 1ns/1ps
`default_nettype none
module pwmc_trig_src (
  input  wire logic       aclk,
  output var  logic [4:0] pins
);
  initial pins = 5'h00;
  // each level lasts 6 edges so the input filter always agrees
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge aclk);
      pins[idx] <= 1'b1;
      repeat (6) @(posedge aclk);
      pins[idx] <= 1'b0;
      repeat (6) @(posedge aclk);
    end
  endtask
  task automatic level(input int idx, input logic v);
    @(posedge aclk);
    pins[idx] <= v;
  endtask
endmodule // pwmc_trig_src
`default_nettype wire

// [test/tb_top.sv]
// register-level bench for the pwm-mode counter channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rd_data;
  logic [1:0]  rd_resp;
  wire  logic  awready, wready, bvalid, arready, rvalid, pwm, pwm_n;
  wire  logic  overflow, underflow, compare_hit, terminal_event;
  wire  logic [31:0] rdata;
  wire  logic [1:0]  bresp, rresp;
  wire  logic [4:0]  pins;
  int          errors, samples_checked, n_ov, n_un, n_hit, n_tc, m;
  localparam logic [31:0] P = 32'h6;

  pwmc_top DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .reload_in(pins[0]), .start_in(pins[1]),
    .kill_in(pins[2]), .count_in(pins[3]), .swap_in(pins[4]), .pwm(pwm),
    .pwm_n(pwm_n), .overflow(overflow), .underflow(underflow),
    .compare_hit(compare_hit), .terminal_event(terminal_event));
  pwmc_trig_src SRC (.aclk(aclk), .pins(pins));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    n_ov  += overflow;
    n_un  += underflow;
    n_hit += compare_hit;
    n_tc  += terminal_event;
  end

  task automatic complete_run();
    if (errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    while (!arready) @(posedge aclk);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    rd_data = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    axr(a);
    `CHK(rd_data, e)
  endtask
  // commands are one-cycle pulses; give them time to act
  task automatic cmd(input int b);
    axw(8'h04, 32'h1 << b);
    repeat (4) @(posedge aclk);
  endtask
  task automatic clr();
    n_ov = 0;
    n_un = 0;
    n_hit = 0;
    n_tc = 0;
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    aresetn = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    chk(8'h00, 32'h0000d000);
    chk(8'h20, 32'h000000c0);
    chk(8'h08, 32'h00000002);
    axr(8'h24);
    `CHK(rd_resp, pwmc_pkg::RESP_SLVERR)
    axw(8'h18, P);
    for (m = 0; m < 4; m++) begin
      axw(8'h00, 32'h0000d020 | m);
      axw(8'h0c, 32'h9);
      cmd(0);
      chk(8'h0c, m == 0 ? 32'h0 : m == 1 ? P : 32'h1);
      chk(8'h08, {30'h0, m != 1, 1'b1});
      axw(8'h0c, 32'h3);
      cmd(0);
      chk(8'h0c, 32'h3);
      cmd(2);
      chk(8'h08, {30'h0, m != 1, 1'b0});
    end
    axw(8'h0c, 32'h5);
    cmd(1);
    chk(8'h08, 32'h3);
    axw(8'h20, 32'h0);
    SRC.pulse(3, 3);
    chk(8'h0c, 32'h4);
    cmd(2);
    axw(8'h20, 32'hc0);
    axw(8'h10, 32'h2);
    for (m = 0; m < 3; m++) begin
      axw(8'h00, 32'h0000d004 | m);
      SRC.level(3, 1'b1);
      clr();
      cmd(0);
      repeat (40) @(posedge aclk);
      SRC.level(3, 1'b0);
      chk(8'h08, m == 1 ? 32'h0 : 32'h2);
      `CHK(n_ov, m == 1 ? 0 : 1)
      `CHK(n_un, m == 0 ? 0 : 1)
      `CHK(n_tc, 1)
      `CHK(n_hit, m == 2 ? 2 : 1)
    end
    axw(8'h00, 32'h0000d008); // period swap stays off
    axw(8'h14, 32'h3);
    cmd(3);
    chk(8'h08, 32'h2);
    SRC.level(3, 1'b1);
    cmd(0);
    SRC.pulse(4, 1);
    repeat (20) @(posedge aclk);
    chk(8'h10, 32'h3);
    chk(8'h14, 32'h2);
    axw(8'h20, 32'hf0);
    SRC.level(2, 1'b1);
    repeat (8) @(posedge aclk);
    repeat (16) begin
      @(negedge aclk);
      `CHK({pwm, pwm_n}, 2'b00)
    end
    chk(8'h08, 32'h7);
    SRC.level(2, 1'b0);
    repeat (8) @(posedge aclk);
    repeat (8) begin
      @(negedge aclk);
      `CHK(pwm_n, ~pwm)
    end
    // sync kill: suppression outlives the pin until a clean terminal event
    axw(8'h00, 32'h0000d048);
    SRC.level(2, 1'b1);
    repeat (8) @(posedge aclk);
    chk(8'h08, 32'h7);
    SRC.level(2, 1'b0);
    repeat (20) @(posedge aclk);
    chk(8'h08, 32'h3);
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
